/* core/cacw_consts.vh */
/*
 holds the register offsets, field positions, reset values and divider
 counts of the counter array compare and watchdog block.
 assumes it is included by bare name from the design file.
*/
`ifndef CACW_CONSTS_VH
`define CACW_CONSTS_VH

`define CACW_NUM_MOD 5
`define CACW_WDT_IDX 3'h4

`define CACW_ADDR_CTRL 8'h00
`define CACW_ADDR_MODE 8'h01
`define CACW_ADDR_CNT_LO 8'h02
`define CACW_ADDR_CNT_HI 8'h03
`define CACW_MMODE_BASE 8'h08
`define CACW_CMPL_BASE 8'h10
`define CACW_CMPH_BASE 8'h18

`define CACW_CTRL_RUN 6
`define CACW_CTRL_FLAG_HI 4

`define CACW_AMODE_IDLE 7
`define CACW_AMODE_WATCHDOG_ENABLE 6
`define CACW_AMODE_CPS_HI 3
`define CACW_AMODE_CPS_LO 1
`define CACW_AMODE_RST 8'h40

`define CACW_MM_ECOM 6
`define CACW_MM_MAT 3
`define CACW_MM_TOG 2
`define CACW_MM_PWM 1
`define CACW_MM_IRQEN 0
`define CACW_MM_RST 7'h00
`define CACW_MM_SWTIMER 7'h48

`define CACW_CPS_DIV12 3'h0
`define CACW_CPS_DIV4 3'h1
`define CACW_CPS_T0OVF 3'h2
`define CACW_CPS_EXTIN 3'h3
`define CACW_CPS_SYS 3'h4

`define CACW_DIV_LAST 4'hb
`define CACW_DIV4_PHASE 2'h3
`define CACW_WDT_LOW_AT 8'h00

`define CACW_ZERO8 8'h00
`define CACW_ZERO16 16'h0000

`endif

/* core/cacw_top.v */
/*
 holds the compare side of a programmable counter array: a 16-bit array
 counter, five compare modules with software timer and frequency output
 modes, and the watchdog function of module 4, behind a byte-wide
 register port.
 assumes a single 40 MHz clock, synchronous inputs, a master that issues
 one-cycle read or write strobes, and chip reset logic that acts on
 o_wdt_reset.
*/
`timescale 1ns/1ps
`include "cacw_consts.vh"

// Summary of operation
// - software timer compares the array counter with the 16-bit compare value
// - a compare match sets that module's compare flag
// - flag set with its interrupt enabled raises the interrupt request
// - flags stay set until software clears them
// - compare enable plus match flag enable selects software timer mode
// - low byte write clears compare enable, high byte write sets it
// - in frequency mode the high byte is the half period in array clocks
// - a high byte of zero means a half period of 256 array clocks
// - low byte matches counter low byte: toggle pin, add high byte
// - frequency mode needs compare, toggle and pulse width enables
// - frequency mode with match flag enable sets flag on 16-bit match
// - watchdog module compares its high byte, low byte is the offset
// - watchdog comes out of every reset enabled
// - watchdog on forces the counter to run and blocks counter writes
// - watchdog on freezes clock select and idle halt, ignores module 4 mode writes
// - watchdog on: counter run writes do not change counter state
// - counter run reads what software wrote, zero if never enabled
// - watchdog update byte matching counter high byte resets the chip
// - update write loads counter high byte plus the offset byte
module cacw_top (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_cpu_idle,
  input wire i_timer0_ovf,
  input wire i_ext_count,
  input wire i_ext_osc_tick,
  output reg [7:0] o_rdata,
  output reg o_cmp_irq,
  output reg o_wdt_reset,
  output reg [4:0] o_module_output_pin
);

  function reg_hit;
    input [7:0] a;
    input [7:0] base;
    input [2:0] idx;
    begin
      reg_hit = (a == (base + {5'h00, idx}));
    end
  endfunction

  reg rst_meta;
  reg rst_sync;
  wire rst_n;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  reg [15:0] counter;
  reg counter_run;
  reg [4:0] compare_flag;
  reg watchdog_enable;
  reg idle_halt_control;
  reg [2:0] counter_clock_select;
  reg [3:0] div_cnt;

  wire [4:0] flag_set;
  wire [4:0] irq_en;
  wire [4:0] wdt_hit;
  wire [4:0] pin_q;
  wire [34:0] mode_w;
  wire [39:0] clo_w;
  wire [39:0] chi_w;

  wire wr_ctrl = i_wr && (i_addr == `CACW_ADDR_CTRL);
  wire wr_amode = i_wr && (i_addr == `CACW_ADDR_MODE);
  wire wr_cnt_lo = i_wr && (i_addr == `CACW_ADDR_CNT_LO);
  wire wr_cnt_hi = i_wr && (i_addr == `CACW_ADDR_CNT_HI);

  // divide-by-12 and divide-by-4 enables share one counter
  wire tick12 = (div_cnt == `CACW_DIV_LAST);
  wire tick4 = (div_cnt[1:0] == `CACW_DIV4_PHASE);
  reg base_tick;

  always @* begin
    case (counter_clock_select)
      `CACW_CPS_DIV12: base_tick = tick12;
      `CACW_CPS_DIV4: base_tick = tick4;
      `CACW_CPS_T0OVF: base_tick = i_timer0_ovf;
      `CACW_CPS_EXTIN: base_tick = i_ext_count;
      `CACW_CPS_SYS: base_tick = 1'b1;
      default: base_tick = i_ext_osc_tick;
    endcase
  end

  wire run_eff = counter_run | watchdog_enable;
  wire halted = idle_halt_control & i_cpu_idle;
  wire cnt_tick = base_tick & run_eff & ~halted;

  reg [3:0] next_div_cnt;

  always @* begin
    next_div_cnt = div_cnt + 4'h1;
    if (tick12) begin
      next_div_cnt = 4'h0;
    end
  end

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  reg [15:0] next_counter;
  reg next_counter_run;
  reg [4:0] next_compare_flag;
  reg next_watchdog_enable;
  reg next_idle_halt_control;
  reg [2:0] next_counter_clock_select;

  // counter writes are refused under the watchdog so software cannot
  // hold it off by rewinding the counter; a write beats the increment
  always @* begin
    next_counter = counter;
    if (wr_cnt_lo && !watchdog_enable) begin
      next_counter = {counter[15:8], i_wdata};
    end else if (wr_cnt_hi && !watchdog_enable) begin
      next_counter = {i_wdata, counter[7:0]};
    end else if (cnt_tick) begin
      next_counter = counter + 16'h0001;
    end
  end

  // a hardware set in the same cycle as a software clear wins
  always @* begin
    next_counter_run = counter_run;
    next_compare_flag = compare_flag | flag_set;
    if (wr_ctrl) begin
      // stored even under the watchdog so it reads back as written
      next_counter_run = i_wdata[`CACW_CTRL_RUN];
      next_compare_flag = i_wdata[`CACW_CTRL_FLAG_HI:0] | flag_set;
    end
  end

  // the freeze looks at the old enable, so the write that turns the
  // watchdog off cannot also move the clock select in the same cycle
  always @* begin
    next_watchdog_enable = watchdog_enable;
    next_idle_halt_control = idle_halt_control;
    next_counter_clock_select = counter_clock_select;
    if (wr_amode) begin
      next_watchdog_enable = i_wdata[`CACW_AMODE_WATCHDOG_ENABLE];
      if (!watchdog_enable) begin
        next_idle_halt_control = i_wdata[`CACW_AMODE_IDLE];
        next_counter_clock_select =
          i_wdata[`CACW_AMODE_CPS_HI:`CACW_AMODE_CPS_LO];
      end
    end
  end

  // counter and array-level control
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= `CACW_ZERO16;
      counter_run <= 1'b0;
      compare_flag <= 5'h00;
      watchdog_enable <= 1'b1;
      idle_halt_control <= 1'b0;
      counter_clock_select <= `CACW_CPS_DIV12;
    end else begin
      counter <= next_counter;
      counter_run <= next_counter_run;
      compare_flag <= next_compare_flag;
      watchdog_enable <= next_watchdog_enable;
      idle_halt_control <= next_idle_halt_control;
      counter_clock_select <= next_counter_clock_select;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `CACW_NUM_MOD; g = g + 1) begin : gen_mod
      localparam integer IDX_I = g;
      localparam [2:0] IDX = IDX_I[2:0];
      reg [6:0] mode;
      reg [7:0] clo;
      reg [7:0] chi;
      reg pin;
      reg [6:0] next_mode;
      reg [7:0] next_clo;
      reg [7:0] next_chi;
      wire is_wdt = (IDX == `CACW_WDT_IDX) && watchdog_enable;
      wire wr_mode = i_wr && reg_hit(i_addr, `CACW_MMODE_BASE, IDX);
      wire wr_lo = i_wr && reg_hit(i_addr, `CACW_CMPL_BASE, IDX);
      wire wr_hi = i_wr && reg_hit(i_addr, `CACW_CMPH_BASE, IDX);
      wire [6:0] eff = is_wdt ? `CACW_MM_SWTIMER : mode;
      wire ecom = eff[`CACW_MM_ECOM];
      wire mat = eff[`CACW_MM_MAT];
      wire freq = ecom & eff[`CACW_MM_TOG] & eff[`CACW_MM_PWM];
      wire full_match = ({chi, clo} == counter);
      wire lo_match = (clo == counter[7:0]);
      wire freq_hit = cnt_tick & freq & lo_match;
      // software timer, and frequency mode with match flag enable, flag on a 16-bit match;
      // the watchdog module instead resets the chip
      assign flag_set[g] = cnt_tick & ecom & mat & full_match & ~is_wdt;
      assign irq_en[g] = eff[`CACW_MM_IRQEN];
      assign wdt_hit[g] = is_wdt & cnt_tick & (chi == counter[15:8]) &
                          (counter[7:0] == `CACW_WDT_LOW_AT);
      assign mode_w[g*7 +: 7] = mode;
      assign clo_w[g*8 +: 8] = clo;
      assign chi_w[g*8 +: 8] = chi;
      assign pin_q[g] = pin;

      always @* begin
        next_mode = mode;
        if (wr_mode && !is_wdt) begin
          next_mode = i_wdata[6:0];
        end else if (wr_lo) begin
          next_mode[`CACW_MM_ECOM] = 1'b0;
        end else if (wr_hi) begin
          next_mode[`CACW_MM_ECOM] = 1'b1;
        end
      end

      // 8-bit wrap makes a zero step a full 256-clock half period;
      // a software write beats the hardware add in the same cycle
      always @* begin
        next_clo = clo;
        if (wr_lo) begin
          next_clo = i_wdata;
        end else if (freq_hit) begin
          next_clo = clo + chi;
        end
      end

      // under the watchdog the written value itself is never used
      always @* begin
        next_chi = chi;
        if (wr_hi && is_wdt) begin
          next_chi = counter[15:8] + clo;
        end else if (wr_hi) begin
          next_chi = i_wdata;
        end
      end

      always @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mode <= `CACW_MM_RST;
          clo <= `CACW_ZERO8;
          chi <= `CACW_ZERO8;
          pin <= 1'b0;
        end else begin
          mode <= next_mode;
          clo <= next_clo;
          chi <= next_chi;
          if (freq_hit) begin
            pin <= ~pin;
          end
        end
      end
    end
  endgenerate

  reg [7:0] next_rdata;
  integer k;

  always @* begin
    next_rdata = `CACW_ZERO8;
    case (i_addr)
      `CACW_ADDR_CTRL:
        next_rdata = {1'b0, counter_run, 1'b0, compare_flag};
      `CACW_ADDR_MODE:
        next_rdata = {idle_halt_control, watchdog_enable, 2'b00,
                      counter_clock_select, 1'b0};
      `CACW_ADDR_CNT_LO: next_rdata = counter[7:0];
      `CACW_ADDR_CNT_HI: next_rdata = counter[15:8];
      default: begin
        for (k = 0; k < `CACW_NUM_MOD; k = k + 1) begin
          if (reg_hit(i_addr, `CACW_MMODE_BASE, k[2:0])) begin
            next_rdata = {1'b0, mode_w[k*7 +: 7]};
          end
          if (reg_hit(i_addr, `CACW_CMPL_BASE, k[2:0])) begin
            next_rdata = clo_w[k*8 +: 8];
          end
          if (reg_hit(i_addr, `CACW_CMPH_BASE, k[2:0])) begin
            next_rdata = chi_w[k*8 +: 8];
          end
        end
      end
    endcase
  end

  // read data stand for one cycle only and are zero otherwise
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= `CACW_ZERO8;
    end else begin
      o_rdata <= i_rd ? next_rdata : `CACW_ZERO8;
    end
  end

  // the request lags the flags by one cycle to keep the output registered
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmp_irq <= 1'b0;
    end else begin
      o_cmp_irq <= |(compare_flag & irq_en);
    end
  end

  // one-cycle request; the chip reset logic must act on it
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wdt_reset <= 1'b0;
    end else begin
      o_wdt_reset <= |wdt_hit;
    end
  end

  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_module_output_pin <= 5'h00;
    end else begin
      o_module_output_pin <= pin_q;
    end
  end

endmodule

/* testbench/cacw_monitor.sv */
/*
 port-level checker for the compare and watchdog block.
 assumes it is bound to cacw_top and sees only its ports.
*/
`timescale 1ns/1ps
`include "cacw_consts.vh"
module cacw_monitor (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_cpu_idle,
  input wire i_timer0_ovf,
  input wire i_ext_count,
  input wire i_ext_osc_tick,
  input wire [7:0] o_rdata,
  input wire o_cmp_irq,
  input wire o_wdt_reset,
  input wire [4:0] o_module_output_pin
);
  default clocking mon_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence ctrl_read;
    $past(i_rd) && $past(i_addr) == `CACW_ADDR_CTRL;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside the read slot");
  AST_UNMAPPED: assert property
    ($past(i_rd) && $past(i_addr) >= 8'h20 |-> o_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  AST_CTRL_BITS: assert property
    (ctrl_read |-> o_rdata[7] == 1'b0 && o_rdata[5] == 1'b0)
    else $error("unused control bits read nonzero");
  AST_MODE_BITS: assert property ($past(i_rd) &&
    $past(i_addr) == `CACW_ADDR_MODE |-> o_rdata[5:4] == 2'h0 && !o_rdata[0])
    else $error("unused array mode bits read nonzero");
  AST_IRQ_HOLD: assert property
    ($fell(o_cmp_irq) |-> $past(i_wr) || $past(i_wr, 2))
    else $error("interrupt dropped without a software write");
  AST_IRQ_FLAG: assert property
    (ctrl_read and o_rdata[4:0] == 5'h00 |-> !o_cmp_irq)
    else $error("interrupt high with every compare flag clear");
  AST_WDT_PULSE: assert property (o_wdt_reset |=> !o_wdt_reset)
    else $error("watchdog reset longer than one cycle");
  AST_WDT_SPACING: assert property
    (o_wdt_reset ##1 !o_wdt_reset |=> !o_wdt_reset [*8])
    else $error("watchdog reset repeated within one pass");
  cover property ($rose(o_cmp_irq));
  cover property (o_wdt_reset);
  cover property ($changed(o_module_output_pin));
  cover property (ctrl_read and o_rdata[0]);
endmodule

/* testbench/cacw_top_tb_top.sv */
/*
 self-checking bench for cacw_top: register, timer, frequency output
 and watchdog tests through the byte register port.
 assumes the design header is on the include path.
*/
`timescale 1ns/1ps
`include "cacw_consts.vh"
module cacw_top_tb_top;
  reg i_ref_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_cpu_idle = 1'b0;
  wire [7:0] o_rdata;
  wire o_cmp_irq;
  wire o_wdt_reset;
  wire [4:0] o_module_output_pin;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  always #12.5 i_ref_clk = ~i_ref_clk;
  // unused clock sources are tied: the bench runs on the every-clock select
  cacw_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cpu_idle(i_cpu_idle),
    .i_timer0_ovf(1'b0), .i_ext_count(1'b0), .i_ext_osc_tick(1'b0),
    .o_rdata(o_rdata), .o_cmp_irq(o_cmp_irq), .o_wdt_reset(o_wdt_reset),
    .o_module_output_pin(o_module_output_pin));
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  // edges until pin 1 next changes; capped so a dead pin cannot hang
  task gap(output int c);
    reg p;
    p = o_module_output_pin[1];
    c = 0;
    while (o_module_output_pin[1] === p && c < 600) begin
      @(posedge i_ref_clk);
      #1;
      c++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    rd(`CACW_ADDR_MODE, `CACW_AMODE_RST);
    rd(`CACW_ADDR_CTRL, 8'h00);
    rd(8'h7f, 8'h00);
    wr(`CACW_ADDR_MODE, 8'hc8);
    rd(`CACW_ADDR_MODE, 8'h40);
    wr(`CACW_ADDR_MODE, 8'h00);
    wr(`CACW_ADDR_MODE, 8'h08);
    rd(`CACW_ADDR_MODE, 8'h08);
    wr(`CACW_ADDR_CNT_LO, 8'h00);
    wr(`CACW_ADDR_CNT_HI, 8'h00);
    rd(`CACW_ADDR_CNT_LO, 8'h00);
    // idle halt: a running counter must not move while the cpu idles
    i_cpu_idle <= 1'b1;
    wr(`CACW_ADDR_MODE, 8'h88);
    wr(`CACW_ADDR_CTRL, 8'h40);
    rd(`CACW_ADDR_CNT_LO, 8'h00);
    i_cpu_idle <= 1'b0;
    wr(`CACW_ADDR_CTRL, 8'h00);
    wr(`CACW_ADDR_MODE, 8'h08);
    wr(`CACW_ADDR_CNT_LO, 8'h00);
    $display("test registers done");
    wr(`CACW_MMODE_BASE, 8'h49);
    wr(`CACW_CMPL_BASE, 8'h20);
    rd(`CACW_MMODE_BASE, 8'h09);
    wr(`CACW_CMPH_BASE, 8'h00);
    rd(`CACW_MMODE_BASE, 8'h49);
    wr(`CACW_ADDR_CTRL, 8'h40);
    n = 0;
    while (o_cmp_irq !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk(n > 28 && n < 40, 1);
    rd(`CACW_ADDR_CTRL, 8'h41);
    repeat (20) @(posedge i_ref_clk);
    rd(`CACW_ADDR_CTRL, 8'h41);
    wr(`CACW_ADDR_CTRL, 8'h40);
    rd(`CACW_ADDR_CTRL, 8'h40);
    chk(o_cmp_irq, 1'b0);
    $display("test software timer done");
    for (int k = 0; k < 2; k++) begin
      wr(`CACW_MMODE_BASE + 8'h01, 8'h46);
      wr(`CACW_CMPL_BASE + 8'h01, 8'h00);
      wr(`CACW_CMPH_BASE + 8'h01, k ? 8'h00 : 8'h04);
      gap(n);
      gap(n);
      chk(n, k ? 256 : 4);
    end
    $display("test frequency output done");
    wr(`CACW_ADDR_CTRL, 8'h00);
    wr(`CACW_ADDR_CNT_LO, 8'h00);
    wr(`CACW_ADDR_CNT_HI, 8'h00);
    wr(`CACW_CMPL_BASE + 8'h04, 8'h02);
    wr(`CACW_ADDR_MODE, 8'h48);
    rd(`CACW_ADDR_CTRL, 8'h00);
    wr(`CACW_ADDR_CNT_HI, 8'h01);
    wr(`CACW_MMODE_BASE + 8'h04, 8'h4f);
    rd(`CACW_MMODE_BASE + 8'h04, 8'h00);
    wr(`CACW_CMPH_BASE + 8'h04, 8'h77);
    rd(`CACW_CMPH_BASE + 8'h04, 8'h02);
    n = 0;
    while (o_wdt_reset !== 1'b1 && n < 1000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk(n > 440 && n < 512, 1);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    rd(`CACW_ADDR_MODE, `CACW_AMODE_RST);
    $display("test watchdog done");
    end_sim;
  end
endmodule
bind cacw_top cacw_monitor u_mon (.i_ref_clk(i_ref_clk),
  .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .i_cpu_idle(i_cpu_idle), .i_timer0_ovf(i_timer0_ovf),
  .i_ext_count(i_ext_count), .i_ext_osc_tick(i_ext_osc_tick),
  .o_rdata(o_rdata), .o_cmp_irq(o_cmp_irq), .o_wdt_reset(o_wdt_reset),
  .o_module_output_pin(o_module_output_pin));
